// file: hw/oscen_ctrl.sv
// Oscillator enable, stabilization and system clock source control
//
// Operation
// - After initial reset the internal oscillator is the system clock source.
// - Two-bit frequency select: 3=2, 2=4, 1=12, 0=8 MHz; resets to 1.
// - Internal oscillator enable bit runs the oscillator; resets to 1.
// - Internal oscillator stops during sleep whatever its enable bit says.
// - Sleep exit forces internal oscillator on and selects it as source.
// - Internal clock gated until 8/16/32/64 own cycles; select resets to 0.
// - High-speed oscillator enable bit runs it; resets to 0.
// - High-speed oscillator stops during sleep regardless of its enable.
// - High-speed clock gated until 128/256/512/1024 cycles; select resets to 0.
// - High-speed wait enable resets to 1; clearing it passes the clock at once.
// - Low-speed oscillator enable bit runs it; resets to 0.
// - Low-speed oscillator stops during sleep regardless of its enable.
// - Low-speed clock gated until 256 of its own cycles complete.
// - Low-speed wait enable resets to 1; clearing it bypasses the gating.
// - Build parameter includes or omits the high-speed oscillator.
// - Source writes naming an oscillator whose enable bit is clear are ignored.
// - The oscillator selected as source cannot be disabled.
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "oscen_defines.svh"
module oscen_ctrl
    import oscen_pkg::*;
#(
    parameter bit HS_PRESENT = 1'b1
) (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire oscen_addr_t reg_addr,
    input  wire oscen_word_t reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output var  oscen_word_t reg_rdata,
    input  wire logic        sleep_mode,
    input  wire logic        internal_rc_osc_clk,
    input  wire logic        lowspeed_crystal_osc_clk,
    input  wire logic        highspeed_resonator_osc_clk,
    output var  logic        internal_osc_run,
    output var  logic        lowspeed_osc_run,
    output var  logic        highspeed_osc_run,
    output var  oscen_sel_t  internal_freq_select,
    output logic             internal_clk_ready,
    output logic             lowspeed_clk_ready,
    output logic             highspeed_clk_ready,
    output var  oscen_sel_t  sysclk_source_select,
    output var  logic        sysclk_ready
);

    function automatic logic addr_hit(input oscen_addr_t a, input oscen_addr_t b);
        addr_hit = (a == b);
    endfunction : addr_hit

    function automatic oscen_count_t internal_wait_cycles(input oscen_sel_t sel);
        case (sel)
            2'h3:    internal_wait_cycles = `OSCEN_IWAIT_3;
            2'h2:    internal_wait_cycles = `OSCEN_IWAIT_2;
            2'h1:    internal_wait_cycles = `OSCEN_IWAIT_1;
            default: internal_wait_cycles = `OSCEN_IWAIT_0;
        endcase
    endfunction : internal_wait_cycles

    function automatic oscen_count_t highspeed_wait_cycles(input oscen_sel_t sel);
        case (sel)
            2'h3:    highspeed_wait_cycles = `OSCEN_HWAIT_3;
            2'h2:    highspeed_wait_cycles = `OSCEN_HWAIT_2;
            2'h1:    highspeed_wait_cycles = `OSCEN_HWAIT_1;
            default: highspeed_wait_cycles = `OSCEN_HWAIT_0;
        endcase
    endfunction : highspeed_wait_cycles

    logic        internal_osc_enable_r;
    logic        lowspeed_osc_enable_r;
    logic        highspeed_osc_enable_r;
    oscen_sel_t  internal_wait_select_r;
    oscen_sel_t  highspeed_wait_select_r;
    logic        lowspeed_wait_enable_r;
    logic        highspeed_wait_enable_r;
    logic        sleep_d_r;
    logic        sleep_exit;
    logic        wr_ctl;
    logic        wr_freq;
    logic        wr_wce;
    logic        wr_src;
    oscen_sel_t  src_req;
    logic        src_allowed;
    logic        internal_tick;
    logic        lowspeed_tick;
    oscen_word_t stat_word;
    oscen_word_t rd_mux;

    assign wr_ctl  = reg_wr & addr_hit(reg_addr, `OSCEN_ADDR_CTL);
    assign wr_freq = reg_wr & addr_hit(reg_addr, `OSCEN_ADDR_FREQ);
    assign wr_wce  = reg_wr & addr_hit(reg_addr, `OSCEN_ADDR_WCE);
    assign wr_src  = reg_wr & addr_hit(reg_addr, `OSCEN_ADDR_SRC);
    assign src_req = reg_wdata[`OSCEN_SRC_HI:`OSCEN_SRC_LO];

    // Sleep release detect; sleep_mode comes from logic on sys_clk
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sleep_d_r <= 1'b0;
        end else begin
            sleep_d_r <= sleep_mode;
        end
    end

    assign sleep_exit = sleep_d_r & ~sleep_mode;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            internal_osc_enable_r <= `OSCEN_IEN_RST;
        end else if (sleep_exit) begin
            internal_osc_enable_r <= 1'b1;
        end else if (wr_ctl) begin
            internal_osc_enable_r <= reg_wdata[`OSCEN_CTL_IEN] |
                (sysclk_source_select == `OSCEN_SRC_INT);
        end
    end

    // Low-speed oscillator enable
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            lowspeed_osc_enable_r <= `OSCEN_LEN_RST;
        end else if (wr_ctl && !sleep_exit) begin
            lowspeed_osc_enable_r <= reg_wdata[`OSCEN_CTL_LEN] |
                (sysclk_source_select == `OSCEN_SRC_LOW);
        end
    end

    // High-speed oscillator enable, absent in builds without it
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            highspeed_osc_enable_r <= `OSCEN_HEN_RST;
        end else if (wr_ctl && !sleep_exit) begin
            highspeed_osc_enable_r <= HS_PRESENT & (reg_wdata[`OSCEN_CTL_HEN] |
                (sysclk_source_select == `OSCEN_SRC_HIGH));
        end
    end

    // Wait time selects
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            internal_wait_select_r  <= `OSCEN_IWT_RST;
            highspeed_wait_select_r <= `OSCEN_HWT_RST;
        end else if (wr_ctl) begin
            internal_wait_select_r  <= reg_wdata[`OSCEN_CTL_IWT_HI:`OSCEN_CTL_IWT_LO];
            highspeed_wait_select_r <= HS_PRESENT ?
                reg_wdata[`OSCEN_CTL_HWT_HI:`OSCEN_CTL_HWT_LO] : `OSCEN_HWT_RST;
        end
    end

    // Internal frequency select
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            internal_freq_select <= `OSCEN_FREQ_RST;
        end else if (wr_freq) begin
            internal_freq_select <= reg_wdata[`OSCEN_FREQ_HI:`OSCEN_FREQ_LO];
        end
    end

    // Wait-enable bits
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            lowspeed_wait_enable_r  <= `OSCEN_LWE_RST;
            highspeed_wait_enable_r <= `OSCEN_HWE_RST;
        end else if (wr_wce) begin
            lowspeed_wait_enable_r  <= reg_wdata[`OSCEN_WCE_LWE];
            highspeed_wait_enable_r <= reg_wdata[`OSCEN_WCE_HWE] | ~HS_PRESENT;
        end
    end

    always_comb begin
        case (src_req)
            `OSCEN_SRC_INT:  src_allowed = internal_osc_enable_r;
            `OSCEN_SRC_LOW:  src_allowed = lowspeed_osc_enable_r;
            `OSCEN_SRC_HIGH: src_allowed = HS_PRESENT & highspeed_osc_enable_r;
            default:         src_allowed = 1'b0;
        endcase
    end

    // System clock source select
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sysclk_source_select <= `OSCEN_SRC_RST;
        end else if (sleep_exit) begin
            sysclk_source_select <= `OSCEN_SRC_INT;
        end else if (wr_src && src_allowed) begin
            sysclk_source_select <= src_req;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            internal_osc_run  <= 1'b0;
            lowspeed_osc_run  <= 1'b0;
            highspeed_osc_run <= 1'b0;
        end else begin
            internal_osc_run  <= internal_osc_enable_r & ~sleep_mode;
            lowspeed_osc_run  <= lowspeed_osc_enable_r & ~sleep_mode;
            highspeed_osc_run <= highspeed_osc_enable_r & ~sleep_mode;
        end
    end

    oscen_sync u_internal_sync (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in (internal_rc_osc_clk),
        .tick     (internal_tick)
    );

    oscen_stab u_internal_stab (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .run      (internal_osc_run),
        .tick     (internal_tick),
        .wait_en  (1'b1),
        .target   (internal_wait_cycles(internal_wait_select_r)),
        .ready    (internal_clk_ready)
    );

    oscen_sync u_lowspeed_sync (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in (lowspeed_crystal_osc_clk),
        .tick     (lowspeed_tick)
    );

    oscen_stab u_lowspeed_stab (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .run      (lowspeed_osc_run),
        .tick     (lowspeed_tick),
        .wait_en  (lowspeed_wait_enable_r),
        .target   (`OSCEN_LWAIT),
        .ready    (lowspeed_clk_ready)
    );

    // High-speed path exists only when built in
    generate
        if (HS_PRESENT) begin : g_highspeed
            logic highspeed_tick;

            oscen_sync u_highspeed_sync (
                .sys_clk  (sys_clk),
                .reset_n  (reset_n),
                .async_in (highspeed_resonator_osc_clk),
                .tick     (highspeed_tick)
            );

            oscen_stab u_highspeed_stab (
                .sys_clk  (sys_clk),
                .reset_n  (reset_n),
                .run      (highspeed_osc_run),
                .tick     (highspeed_tick),
                .wait_en  (highspeed_wait_enable_r),
                .target   (highspeed_wait_cycles(highspeed_wait_select_r)),
                .ready    (highspeed_clk_ready)
            );
        end else begin : g_no_highspeed
            always_ff @(posedge sys_clk) begin
                highspeed_clk_ready <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sysclk_ready <= 1'b0;
        end else begin
            case (sysclk_source_select)
                `OSCEN_SRC_INT:  sysclk_ready <= internal_clk_ready;
                `OSCEN_SRC_LOW:  sysclk_ready <= lowspeed_clk_ready;
                `OSCEN_SRC_HIGH: sysclk_ready <= highspeed_clk_ready;
                default:         sysclk_ready <= 1'b0;
            endcase
        end
    end

    // Status word
    always_comb begin
        stat_word                     = '0;
        stat_word[`OSCEN_STAT_IRUN]   = internal_osc_run;
        stat_word[`OSCEN_STAT_LRUN]   = lowspeed_osc_run;
        stat_word[`OSCEN_STAT_HRUN]   = highspeed_osc_run;
        stat_word[`OSCEN_STAT_IRDY]   = internal_clk_ready;
        stat_word[`OSCEN_STAT_LRDY]   = lowspeed_clk_ready;
        stat_word[`OSCEN_STAT_HRDY]   = highspeed_clk_ready;
        stat_word[`OSCEN_STAT_SRDY]   = sysclk_ready;
    end

    // Read decode; unmapped offsets read zero
    always_comb begin
        rd_mux = '0;
        if (addr_hit(reg_addr, `OSCEN_ADDR_CTL)) begin
            rd_mux[`OSCEN_CTL_IEN]                     = internal_osc_enable_r;
            rd_mux[`OSCEN_CTL_LEN]                     = lowspeed_osc_enable_r;
            rd_mux[`OSCEN_CTL_HEN]                     = highspeed_osc_enable_r;
            rd_mux[`OSCEN_CTL_IWT_HI:`OSCEN_CTL_IWT_LO] = internal_wait_select_r;
            rd_mux[`OSCEN_CTL_HWT_HI:`OSCEN_CTL_HWT_LO] = highspeed_wait_select_r;
        end else if (addr_hit(reg_addr, `OSCEN_ADDR_FREQ)) begin
            rd_mux[`OSCEN_FREQ_HI:`OSCEN_FREQ_LO] = internal_freq_select;
        end else if (addr_hit(reg_addr, `OSCEN_ADDR_WCE)) begin
            rd_mux[`OSCEN_WCE_LWE] = lowspeed_wait_enable_r;
            rd_mux[`OSCEN_WCE_HWE] = highspeed_wait_enable_r;
        end else if (addr_hit(reg_addr, `OSCEN_ADDR_SRC)) begin
            rd_mux[`OSCEN_SRC_HI:`OSCEN_SRC_LO] = sysclk_source_select;
        end else if (addr_hit(reg_addr, `OSCEN_ADDR_STAT)) begin
            rd_mux = stat_word;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule : oscen_ctrl
`default_nettype wire

// file: hw/oscen_defines.svh
// Register offsets, field positions, reset values and wait counts of the oscillator control
`ifndef OSCEN_DEFINES_SVH
`define OSCEN_DEFINES_SVH

// Register offsets (word index on the plain register port)
`define OSCEN_ADDR_CTL      4'h0
`define OSCEN_ADDR_FREQ     4'h1
`define OSCEN_ADDR_WCE      4'h2
`define OSCEN_ADDR_SRC      4'h3
`define OSCEN_ADDR_STAT     4'h4

// Control register fields
`define OSCEN_CTL_IEN       0
`define OSCEN_CTL_LEN       1
`define OSCEN_CTL_HEN       2
`define OSCEN_CTL_IWT_LO    4
`define OSCEN_CTL_IWT_HI    5
`define OSCEN_CTL_HWT_LO    6
`define OSCEN_CTL_HWT_HI    7

// Frequency register field
`define OSCEN_FREQ_LO       0
`define OSCEN_FREQ_HI       1

// Wait-enable register fields
`define OSCEN_WCE_LWE       0
`define OSCEN_WCE_HWE       1

// Source register field
`define OSCEN_SRC_LO        0
`define OSCEN_SRC_HI        1

// Status register fields
`define OSCEN_STAT_IRUN     0
`define OSCEN_STAT_LRUN     1
`define OSCEN_STAT_HRUN     2
`define OSCEN_STAT_IRDY     4
`define OSCEN_STAT_LRDY     5
`define OSCEN_STAT_HRDY     6
`define OSCEN_STAT_SRDY     8

// Reset values
`define OSCEN_IEN_RST       1'h1
`define OSCEN_LEN_RST       1'h0
`define OSCEN_HEN_RST       1'h0
`define OSCEN_FREQ_RST      2'h1
`define OSCEN_IWT_RST       2'h0
`define OSCEN_HWT_RST       2'h0
`define OSCEN_LWE_RST       1'h1
`define OSCEN_HWE_RST       1'h1
`define OSCEN_SRC_RST       2'h0

// Source encodings
`define OSCEN_SRC_INT       2'h0
`define OSCEN_SRC_LOW       2'h1
`define OSCEN_SRC_HIGH      2'h2
`define OSCEN_SRC_RSVD      2'h3

// Stabilization counts in oscillator cycles
`define OSCEN_IWAIT_0       11'h040
`define OSCEN_IWAIT_1       11'h020
`define OSCEN_IWAIT_2       11'h010
`define OSCEN_IWAIT_3       11'h008
`define OSCEN_HWAIT_0       11'h400
`define OSCEN_HWAIT_1       11'h200
`define OSCEN_HWAIT_2       11'h100
`define OSCEN_HWAIT_3       11'h080
`define OSCEN_LWAIT         11'h100

`endif

// file: hw/oscen_pkg.sv
// Types shared by the oscillator control modules
package oscen_pkg;
    typedef logic [1:0]  oscen_sel_t;
    typedef logic [3:0]  oscen_addr_t;
    typedef logic [15:0] oscen_word_t;
    typedef logic [10:0] oscen_count_t;
endpackage : oscen_pkg

// file: hw/oscen_sync.sv
// Two-flop synchroniser with rising-edge pulse for an oscillator clock pin
`timescale 1ns/1ps
`default_nettype none
module oscen_sync (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic async_in,
    output var  logic tick
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
            tick   <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
            last_r <= sync_r;
            tick   <= sync_r & ~last_r;
        end
    end
endmodule : oscen_sync
`default_nettype wire

// file: hw/oscen_stab.sv
// Stabilization wait counter gating one oscillator clock
`timescale 1ns/1ps
`default_nettype none
module oscen_stab
    import oscen_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         reset_n,
    input  wire logic         run,
    input  wire logic         tick,
    input  wire logic         wait_en,
    input  wire oscen_count_t target,
    output var  logic         ready
);
    oscen_count_t count_r;

    // Cleared while stopped, restarts from zero on resume
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            count_r <= '0;
        end else if (!run) begin
            count_r <= '0;
        end else if (tick && (count_r < target)) begin
            count_r <= count_r + 11'h001;
        end
    end

    // Clock released when the count completes or waiting is bypassed
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ready <= 1'b0;
        end else begin
            ready <= run & (~wait_en | (count_r >= target));
        end
    end
endmodule : oscen_stab
`default_nettype wire

// file: bench/oscen_ctrl_monitor.sv
// Assertion checker for the oscillator control ports
`timescale 1ns/1ps
`default_nettype none
module oscen_ctrl_monitor
    import oscen_pkg::*;
#(
    parameter bit HS_PRESENT = 1'b1
) (
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire oscen_addr_t reg_addr,
    input wire oscen_word_t reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire oscen_word_t reg_rdata,
    input wire logic        sleep_mode,
    input wire logic        internal_osc_run,
    input wire logic        lowspeed_osc_run,
    input wire logic        highspeed_osc_run,
    input wire oscen_sel_t  internal_freq_select,
    input wire logic        internal_clk_ready,
    input wire logic        lowspeed_clk_ready,
    input wire logic        highspeed_clk_ready,
    input wire oscen_sel_t  sysclk_source_select,
    input wire logic        sysclk_ready
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    property p_sleep_stop;
        sleep_mode [*2] |-> !internal_osc_run && !lowspeed_osc_run && !highspeed_osc_run;
    endproperty
    a_sleep_stop: assert property (p_sleep_stop)
        else $error("run in sleep");

    property p_sleep_exit;
        $fell(sleep_mode) |-> ##[1:4] (sysclk_source_select == 2'h0 && internal_osc_run);
    endproperty
    a_sleep_exit: assert property (p_sleep_exit)
        else $error("wake source");

    property p_src_legal;
        sysclk_source_select != 2'h3 && (HS_PRESENT || sysclk_source_select != 2'h2);
    endproperty
    a_src_legal: assert property (p_src_legal)
        else $error("bad source");

    property p_src_runs;
        !sleep_mode && !$past(sleep_mode) && $past(reset_n) |->
            (sysclk_source_select != 2'h1 || lowspeed_osc_run) &&
            (sysclk_source_select != 2'h2 || highspeed_osc_run);
    endproperty
    a_src_runs: assert property (p_src_runs)
        else $error("source stopped");

    property p_src_write;
        $changed(sysclk_source_select) |-> sysclk_source_select == 2'h0 ||
            ($past(reg_wr) && $past(reg_addr) == 4'h3 && sysclk_source_select == $past(reg_wdata[1:0]));
    endproperty
    a_src_write: assert property (p_src_write)
        else $error("source write");

    property p_freq_write;
        $changed(internal_freq_select) |-> $past(reg_wr) && $past(reg_addr) == 4'h1 &&
            internal_freq_select == $past(reg_wdata[1:0]);
    endproperty
    a_freq_write: assert property (p_freq_write)
        else $error("freq write");

    property p_ready_drop;
        (!internal_osc_run |=> !internal_clk_ready) and
        (!lowspeed_osc_run |=> !lowspeed_clk_ready) and
        (!highspeed_osc_run |=> !highspeed_clk_ready);
    endproperty
    a_ready_drop: assert property (p_ready_drop)
        else $error("ready on stop");

    property p_sysclk_ready;
        $past(reset_n) |-> sysclk_ready == $past(sysclk_source_select == 2'h0 ? internal_clk_ready
            : sysclk_source_select == 2'h1 ? lowspeed_clk_ready
            : sysclk_source_select == 2'h2 && highspeed_clk_ready);
    endproperty
    a_sysclk_ready: assert property (p_sysclk_ready)
        else $error("sysclk ready");

    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("stray rdata");

    c_int_ready: cover property ($rose(internal_clk_ready));
    c_low_src: cover property ($changed(sysclk_source_select) && sysclk_source_select == 2'h1);
    c_wake: cover property ($fell(sleep_mode));
endmodule : oscen_ctrl_monitor

bind oscen_ctrl oscen_ctrl_monitor #(.HS_PRESENT(HS_PRESENT)) oscen_ctrl_monitor_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
    .internal_osc_run(internal_osc_run), .lowspeed_osc_run(lowspeed_osc_run),
    .highspeed_osc_run(highspeed_osc_run), .internal_freq_select(internal_freq_select),
    .internal_clk_ready(internal_clk_ready), .lowspeed_clk_ready(lowspeed_clk_ready),
    .highspeed_clk_ready(highspeed_clk_ready), .sysclk_source_select(sysclk_source_select),
    .sysclk_ready(sysclk_ready)
);
`default_nettype wire

// file: bench/oscen_osc_model.sv
// Behavioural oscillators that stand still while their run input is low
`timescale 1ns/1ps
`default_nettype none
module oscen_osc_model (
    input  wire logic internal_osc_run,
    input  wire logic lowspeed_osc_run,
    input  wire logic highspeed_osc_run,
    output var  logic internal_rc_osc_clk,
    output var  logic lowspeed_crystal_osc_clk,
    output var  logic highspeed_resonator_osc_clk
);
    always #203 internal_rc_osc_clk = internal_osc_run & !internal_rc_osc_clk;
    always #307 lowspeed_crystal_osc_clk = lowspeed_osc_run & !lowspeed_crystal_osc_clk;
    always #251 highspeed_resonator_osc_clk = highspeed_osc_run & !highspeed_resonator_osc_clk;
endmodule : oscen_osc_model
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking testbench for the oscillator control block
`timescale 1ns/1ps
`default_nettype none
`include "oscen_defines.svh"
module tb_top
    import oscen_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    oscen_addr_t reg_addr = 4'h0;
    oscen_word_t reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        sleep_mode = 1'b0;
    oscen_word_t reg_rdata;
    logic        int_clk, low_clk, high_clk, int_run, low_run, high_run;
    logic        i_rdy, l_rdy, h_rdy, s_rdy;
    oscen_sel_t  freq, src;
    int          err_count = 0;
    int          checks = 0;
    int          n;

    always #50 sys_clk = !sys_clk;

    oscen_ctrl #(.HS_PRESENT(1'b1)) oscen_ctrl_i (
        .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
        .internal_rc_osc_clk(int_clk), .lowspeed_crystal_osc_clk(low_clk),
        .highspeed_resonator_osc_clk(high_clk), .internal_osc_run(int_run),
        .lowspeed_osc_run(low_run), .highspeed_osc_run(high_run),
        .internal_freq_select(freq), .internal_clk_ready(i_rdy), .lowspeed_clk_ready(l_rdy),
        .highspeed_clk_ready(h_rdy), .sysclk_source_select(src), .sysclk_ready(s_rdy));
    oscen_osc_model oscen_osc_model_i (
        .internal_osc_run(int_run), .lowspeed_osc_run(low_run), .highspeed_osc_run(high_run),
        .internal_rc_osc_clk(int_clk), .lowspeed_crystal_osc_clk(low_clk),
        .highspeed_resonator_osc_clk(high_clk));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input oscen_word_t e, input oscen_word_t g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
        checks++;
        if (g < lo || g > hi) begin
            err_count++;
            $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask : chk_rng

    task automatic wr(input oscen_addr_t a, input oscen_word_t d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input string nm, input oscen_addr_t a, input oscen_word_t e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(nm, e, reg_rdata);
    endtask : rd

    task automatic wait_rdy(input int i);
        n = 0;
        while ((i == 0 ? i_rdy : i == 1 ? l_rdy : h_rdy) !== 1'b1) begin
            @(posedge sys_clk);
            n++;
            if (n > 8000) begin
                err_count++;
                $display("mismatch ready wait expected done seen timeout");
                print_verdict();
            end
        end
    endtask : wait_rdy

    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic t_reset();
        rd("ctl", `OSCEN_ADDR_CTL, 16'h0001);
        rd("freq", `OSCEN_ADDR_FREQ, 16'h0001);
        rd("wce", `OSCEN_ADDR_WCE, 16'h0003);
        rd("src", `OSCEN_ADDR_SRC, 16'h0000);
        rd("unmapped", 4'hf, 16'h0000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_freq();
        for (int i = 3; i >= 0; i--) begin
            wr(`OSCEN_ADDR_FREQ, 16'(i));
            settle();
            chk("freq port", 16'(i), {14'h0, freq});
        end
        $display("test freq done");
    endtask : t_freq

    task automatic t_low();
        wr(`OSCEN_ADDR_SRC, 16'h0001);
        wr(`OSCEN_ADDR_SRC, 16'h0003);
        wr(`OSCEN_ADDR_SRC, 16'h0002);
        rd("refused src", `OSCEN_ADDR_SRC, 16'h0000);
        wr(`OSCEN_ADDR_CTL, 16'h0003);
        wait_rdy(1);
        chk_rng("low wait", 1563, 1579, n);
        wr(`OSCEN_ADDR_SRC, 16'h0001);
        wr(`OSCEN_ADDR_CTL, 16'h0000);
        rd("keep source on", `OSCEN_ADDR_CTL, 16'h0002);
        settle();
        chk("int stopped", 16'h0000, {14'h0, int_run, i_rdy});
        chk("src low", 16'h0001, {14'h0, src});
        $display("test low done");
    endtask : t_low

    task automatic t_int();
        for (int w = 0; w < 4; w++) begin
            wr(`OSCEN_ADDR_CTL, 16'h0002 | 16'(w << 4));
            settle();
            chk("int ready off", 16'h0000, {15'h0, i_rdy});
            wr(`OSCEN_ADDR_CTL, 16'h0003 | 16'(w << 4));
            wait_rdy(0);
            chk_rng("int wait", ((64 >> w) - 1) * 406 / 100 - 2, (64 >> w) * 406 / 100 + 8, n);
        end
        wr(`OSCEN_ADDR_CTL, 16'h0003);
        $display("test int done");
    endtask : t_int

    task automatic t_high();
        wr(`OSCEN_ADDR_CTL, 16'h00c7);
        wait_rdy(2);
        chk_rng("high wait", 635, 650, n);
        wr(`OSCEN_ADDR_SRC, 16'h0002);
        rd("src high", `OSCEN_ADDR_SRC, 16'h0002);
        wr(`OSCEN_ADDR_SRC, 16'h0000);
        wr(`OSCEN_ADDR_CTL, 16'h0003);
        wr(`OSCEN_ADDR_WCE, 16'h0001);
        wr(`OSCEN_ADDR_CTL, 16'h0007);
        wait_rdy(2);
        chk_rng("high bypass", 0, 8, n);
        wr(`OSCEN_ADDR_CTL, 16'h0005);
        wr(`OSCEN_ADDR_WCE, 16'h0000);
        wr(`OSCEN_ADDR_CTL, 16'h0007);
        wait_rdy(1);
        chk_rng("low bypass", 0, 8, n);
        rd("stat", `OSCEN_ADDR_STAT, 16'h0177);
        $display("test high done");
    endtask : t_high

    task automatic t_sleep();
        wr(`OSCEN_ADDR_WCE, 16'h0003);
        wr(`OSCEN_ADDR_SRC, 16'h0002);
        @(posedge sys_clk);
        sleep_mode <= 1'b1;
        settle();
        chk("runs in sleep", 16'h0000, {13'h0, int_run, low_run, high_run});
        settle();
        chk("readies in sleep", 16'h0000, {13'h0, i_rdy, l_rdy, h_rdy});
        @(posedge sys_clk);
        sleep_mode <= 1'b0;
        repeat (5) @(posedge sys_clk);
        #1 chk("wake state", 16'h0004, {13'h0, int_run, src});
        rd("ctl after wake", `OSCEN_ADDR_CTL, 16'h0007);
        wait_rdy(0);
        chk_rng("int restart", 247, 267, n);
        $display("test sleep done");
    endtask : t_sleep

    initial begin
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_reset();
        t_freq();
        t_low();
        t_int();
        t_high();
        t_sleep();
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
